// ==== rtl/smd_pkg.sv ====
// Overview of operation
// - Private group sends every active lane address to per-item private space.
// - Global group sends every active lane address straight to global memory.
// - Op 16 loads a byte, upper 24 destination bits zero.
// - Op 17 loads a byte, bit 7 copied into all upper bits.
// - Op 18 loads halfword zero-extended; op 19 loads halfword sign-extended.
// - Ops 20-23 load one to four words into consecutive destinations, unconverted.
// - Global op 24 stores data bits 7:0; op 25 stores bits 23:16.
// - Global op 26 stores data bits 15:0; op 27 stores bits 31:16.
// - Global ops 28-31 store one to four words from consecutive data registers.
// - Ops 32/34 put zero-padded byte in bits 15:0; 33/35 in 31:16.
// - Op 36 writes loaded halfword to bits 15:0; op 37 to 31:16.
// - Op 65 takes replacement from data word 0, comparison from word 1.
// - Compare-exchange always writes back, operand on match else old value, and always returns the old value.
// - Ops 68/70 store signed min/max of operand and old word, return old.
// - Ops 69/71 store unsigned min/max of operand and old word, return old.
// - Op 75 writes zero if old >= operand, else old plus one.
// - Op 76 writes operand if old zero or above operand, else old minus one.
// - Ops 96/97 work on word pairs; 97 compares against data words 2:3.
package smd_pkg;

  localparam logic [6:0] OP_LOAD_BYTE_ZERO_EXT = 7'h10;
  localparam logic [6:0] OP_LOAD_BYTE_SIGN_EXT = 7'h11;
  localparam logic [6:0] OP_LOAD_HALF_ZERO_EXT = 7'h12;
  localparam logic [6:0] OP_LOAD_HALF_SIGN_EXT = 7'h13;
  localparam logic [6:0] OP_LOAD_WORD_FIRST = 7'h14;
  localparam logic [6:0] OP_LOAD_WORD_LAST = 7'h17;
  localparam logic [6:0] OP_STORE_BYTE = 7'h18;
  localparam logic [6:0] OP_STORE_BYTE_UPPER_HALF = 7'h19;
  localparam logic [6:0] OP_STORE_HALF = 7'h1a;
  localparam logic [6:0] OP_STORE_HALF_UPPER = 7'h1b;
  localparam logic [6:0] OP_STORE_WORD_FIRST = 7'h1c;
  localparam logic [6:0] OP_STORE_WORD_LAST = 7'h1f;
  localparam logic [6:0] OP_LOAD_BYTE_LOW_HALF = 7'h20;
  localparam logic [6:0] OP_LOAD_BYTE_UPPER_HALF = 7'h21;
  localparam logic [6:0] OP_LOAD_SBYTE_LOW_HALF = 7'h22;
  localparam logic [6:0] OP_LOAD_SBYTE_UPPER_HALF = 7'h23;
  localparam logic [6:0] OP_LOAD_HALF_LOW = 7'h24;
  localparam logic [6:0] OP_LOAD_HALF_UPPER = 7'h25;
  localparam logic [6:0] OP_EXCHANGE = 7'h40;
  localparam logic [6:0] OP_COMPARE_EXCHANGE = 7'h41;
  localparam logic [6:0] OP_ATOM_ADD = 7'h42;
  localparam logic [6:0] OP_ATOM_SUB = 7'h43;
  localparam logic [6:0] OP_ATOM_SMIN = 7'h44;
  localparam logic [6:0] OP_ATOM_UMIN = 7'h45;
  localparam logic [6:0] OP_ATOM_SMAX = 7'h46;
  localparam logic [6:0] OP_ATOM_UMAX = 7'h47;
  localparam logic [6:0] OP_ATOM_AND = 7'h48;
  localparam logic [6:0] OP_ATOM_OR = 7'h49;
  localparam logic [6:0] OP_ATOM_XOR = 7'h4a;
  localparam logic [6:0] OP_WRAP_INCREMENT = 7'h4b;
  localparam logic [6:0] OP_WRAP_DECREMENT = 7'h4c;
  localparam logic [6:0] OP_EXCHANGE_WIDE = 7'h60;
  localparam logic [6:0] OP_COMPARE_EXCHANGE_WIDE = 7'h61;

  localparam logic [31:0] WORD_RST = 32'h0;
  localparam logic [1:0] IDX_RST = 2'h0;
  localparam logic [6:0] OP_RST = 7'h0;

  typedef enum logic {
    SMD_SEG_PRIVATE = 1'b0,
    SMD_SEG_GLOBAL = 1'b1
  } smd_seg_e;

  typedef enum logic [2:0] {
    SMD_IDLE = 3'b000,
    SMD_LOAD = 3'b001,
    SMD_STORE = 3'b010,
    SMD_ATOM_RD = 3'b011,
    SMD_ATOM_WR = 3'b100
  } smd_state_e;

  typedef struct packed {
    logic legal;
    smd_state_e first;
    logic [1:0] last;
  } smd_dec_s;

endpackage

// ==== rtl/smd_atom_if.sv ====
`timescale 1ns/1ps
interface smd_atom_if;
  logic [6:0] op;
  logic [63:0] old_val;
  logic [63:0] operand;
  logic [63:0] compare;
  logic [63:0] new_val;

  modport alu (input op, input old_val, input operand, input compare, output new_val);
  modport ctl (output op, output old_val, output operand, output compare, input new_val);
endinterface

// ==== rtl/smd_atomic_alu.sv ====
`timescale 1ns/1ps
module smd_atomic_alu
  import smd_pkg::*;
(
  smd_atom_if.alu a // Old value in, new value out
);

  logic [31:0] old_w;
  logic [31:0] opd_w;
  logic [31:0] lo_w;
  logic s_less;
  logic u_less;

  assign old_w = a.old_val[31:0];
  assign opd_w = a.operand[31:0];
  assign s_less = $signed(opd_w) < $signed(old_w);
  assign u_less = opd_w < old_w;

  always_comb begin
    lo_w = old_w;
    a.new_val = a.old_val;
    unique case (a.op)
      OP_EXCHANGE: lo_w = opd_w;
      OP_ATOM_ADD: lo_w = old_w + opd_w;
      OP_ATOM_SUB: lo_w = old_w - opd_w;
      OP_ATOM_AND: lo_w = old_w & opd_w;
      OP_ATOM_OR: lo_w = old_w | opd_w;
      OP_ATOM_XOR: lo_w = old_w ^ opd_w;
      OP_ATOM_SMIN: lo_w = s_less ? opd_w : old_w;
      OP_ATOM_SMAX: lo_w = (!s_less && opd_w != old_w) ? opd_w : old_w;
      OP_ATOM_UMIN: lo_w = u_less ? opd_w : old_w;
      OP_ATOM_UMAX: lo_w = (opd_w > old_w) ? opd_w : old_w;
      OP_WRAP_INCREMENT: lo_w = (old_w >= opd_w) ? WORD_RST : old_w + 32'h1;
      OP_WRAP_DECREMENT: lo_w = (old_w == WORD_RST || old_w > opd_w) ? opd_w : old_w - 32'h1;
      OP_COMPARE_EXCHANGE: lo_w = (old_w == a.compare[31:0]) ? opd_w : old_w;
      default: lo_w = old_w;
    endcase
    a.new_val = {a.old_val[63:32], lo_w};
    if (a.op == OP_EXCHANGE_WIDE) begin
      a.new_val = a.operand;
    end else if (a.op == OP_COMPARE_EXCHANGE_WIDE) begin
      a.new_val = (a.old_val == a.compare) ? a.operand : a.old_val;
    end
  end

endmodule

// ==== rtl/smd_decode.sv ====
`timescale 1ns/1ps
module smd_decode
  import smd_pkg::*;
(
  input wire logic i_clk, // Core clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_issue_valid, // Instruction offered
  output logic o_issue_ready, // Idle, can take one
  input wire logic i_issue_seg, // 0 private, 1 global
  input wire logic [6:0] i_issue_op, // Opcode field
  input wire logic [31:0] i_issue_addr, // Lane byte address
  input wire logic [3:0][31:0] i_issue_data, // Data words 0..3
  output logic o_mem_req, // Access request, held to ack
  output logic o_mem_seg, // 0 private, 1 global
  output logic o_mem_we, // Write access
  output logic [31:0] o_mem_addr, // Byte address
  output logic [3:0] o_mem_be, // Byte lanes
  output logic [31:0] o_mem_wdata, // Write data
  output logic o_mem_lock, // Held over an atomic sequence
  input wire logic i_mem_ack, // Access done, one cycle
  input wire logic [31:0] i_mem_rdata, // Read data with ack
  output logic o_wb_valid, // Destination write, one cycle
  output logic [1:0] o_wb_idx, // Destination register offset
  output logic [31:0] o_wb_data, // Destination data
  output logic o_wb_lo_en, // Write bits 15:0
  output logic o_wb_hi_en, // Write bits 31:16
  output logic o_illegal // Opcode refused, one cycle
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic smd_dec_s decode(input logic seg, input logic [6:0] op);
    smd_dec_s d;
    d.legal = 1'b0;
    d.first = SMD_IDLE;
    d.last = IDX_RST;
    if (op >= OP_LOAD_BYTE_ZERO_EXT && op <= OP_LOAD_WORD_LAST) begin
      d.legal = 1'b1;
      d.first = SMD_LOAD;
      if (op >= OP_LOAD_WORD_FIRST) begin
        d.last = op[1:0];
      end
    end else if (seg == SMD_SEG_GLOBAL) begin
      // Private group holds only the plain loads
      if (op >= OP_STORE_BYTE && op <= OP_STORE_WORD_LAST) begin
        d.legal = 1'b1;
        d.first = SMD_STORE;
        if (op >= OP_STORE_WORD_FIRST) begin
          d.last = op[1:0];
        end
      end else if (op >= OP_LOAD_BYTE_LOW_HALF && op <= OP_LOAD_HALF_UPPER) begin
        d.legal = 1'b1;
        d.first = SMD_LOAD;
      end else if (op >= OP_EXCHANGE && op <= OP_WRAP_DECREMENT) begin
        d.legal = 1'b1;
        d.first = SMD_ATOM_RD;
      end else if (op == OP_EXCHANGE_WIDE || op == OP_COMPARE_EXCHANGE_WIDE) begin
        d.legal = 1'b1;
        d.first = SMD_ATOM_RD;
        d.last = 2'h1;
      end
    end
    return d;
  endfunction

  smd_dec_s dec;
  logic accept;

  assign dec = decode(i_issue_seg, i_issue_op);
  assign accept = i_issue_valid && o_issue_ready && dec.legal;

  // ----------------------------------------------------------------
  // Captured instruction
  // ----------------------------------------------------------------
  smd_state_e state_reg;
  logic [6:0] op_reg;
  logic seg_reg;
  logic [31:0] addr_reg;
  logic [3:0][31:0] data_reg;
  logic [1:0] last_reg;
  logic [1:0] idx_reg;
  logic launch_reg;
  logic [63:0] old_reg;
  logic done;

  assign done = o_mem_req && i_mem_ack;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_reg <= OP_RST;
      seg_reg <= SMD_SEG_PRIVATE;
      addr_reg <= WORD_RST;
      data_reg <= '0;
      last_reg <= IDX_RST;
    end else if (accept) begin
      op_reg <= i_issue_op;
      seg_reg <= i_issue_seg;
      addr_reg <= i_issue_addr;
      data_reg <= i_issue_data;
      last_reg <= dec.last;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= SMD_IDLE;
      idx_reg <= IDX_RST;
      launch_reg <= 1'b0;
      o_issue_ready <= 1'b1;
      o_mem_lock <= 1'b0;
    end else if (accept) begin
      state_reg <= dec.first;
      idx_reg <= IDX_RST;
      launch_reg <= 1'b1;
      o_issue_ready <= 1'b0;
      // Lock keeps the read and write of an atomic indivisible
      o_mem_lock <= (dec.first == SMD_ATOM_RD);
    end else if (done) begin
      if (idx_reg != last_reg) begin
        idx_reg <= idx_reg + 2'h1;
        launch_reg <= 1'b1;
      end else if (state_reg == SMD_ATOM_RD) begin
        state_reg <= SMD_ATOM_WR;
        idx_reg <= IDX_RST;
        launch_reg <= 1'b1;
      end else begin
        state_reg <= SMD_IDLE;
        o_issue_ready <= 1'b1;
        o_mem_lock <= 1'b0;
      end
    end else begin
      launch_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_illegal <= 1'b0;
    end else begin
      o_illegal <= i_issue_valid && o_issue_ready && !dec.legal;
    end
  end

  // ----------------------------------------------------------------
  // Atomic datapath
  // ----------------------------------------------------------------
  smd_atom_if atom ();

  assign atom.op = op_reg;
  assign atom.old_val = old_reg;
  // replacement from word 0 (words 0:1 wide), comparison from word 1 (words 2:3 for op 97)
  assign atom.operand = {data_reg[1], data_reg[0]};
  assign atom.compare = (op_reg == OP_COMPARE_EXCHANGE_WIDE) ?
                        {data_reg[3], data_reg[2]} : {WORD_RST, data_reg[1]};

  smd_atomic_alu u_alu (
    .a(atom.alu)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      old_reg <= '0;
    end else if (done && state_reg == SMD_ATOM_RD) begin
      if (idx_reg[0]) begin
        old_reg[63:32] <= i_mem_rdata;
      end else begin
        old_reg[31:0] <= i_mem_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory access
  // ----------------------------------------------------------------
  logic sub_byte;
  logic sub_half;
  logic [31:0] acc_addr;
  logic [3:0] acc_be;
  logic [31:0] acc_wdata;
  logic [7:0] st_byte;
  logic [15:0] st_half;

  assign sub_byte = op_reg == OP_LOAD_BYTE_ZERO_EXT || op_reg == OP_LOAD_BYTE_SIGN_EXT ||
                    (op_reg >= OP_LOAD_BYTE_LOW_HALF && op_reg <= OP_LOAD_SBYTE_UPPER_HALF) ||
                    op_reg == OP_STORE_BYTE || op_reg == OP_STORE_BYTE_UPPER_HALF;
  assign sub_half = op_reg == OP_LOAD_HALF_ZERO_EXT || op_reg == OP_LOAD_HALF_SIGN_EXT ||
                    op_reg == OP_LOAD_HALF_LOW || op_reg == OP_LOAD_HALF_UPPER ||
                    op_reg == OP_STORE_HALF || op_reg == OP_STORE_HALF_UPPER;
  assign st_byte = (op_reg == OP_STORE_BYTE_UPPER_HALF) ? data_reg[0][23:16] : data_reg[0][7:0];
  assign st_half = (op_reg == OP_STORE_HALF_UPPER) ? data_reg[0][31:16] : data_reg[0][15:0];

  always_comb begin
    acc_addr = addr_reg + {28'h0, idx_reg, 2'b00};
    acc_be = 4'hf;
    acc_wdata = data_reg[idx_reg];
    if (sub_byte) begin
      acc_addr = addr_reg;
      acc_be = 4'h1 << addr_reg[1:0];
      acc_wdata = {4{st_byte}};
    end else if (sub_half) begin
      acc_addr = addr_reg;
      acc_be = addr_reg[1] ? 4'hc : 4'h3;
      acc_wdata = {2{st_half}};
    end else if (state_reg == SMD_ATOM_WR) begin
      acc_wdata = idx_reg[0] ? atom.new_val[63:32] : atom.new_val[31:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_req <= 1'b0;
      o_mem_seg <= SMD_SEG_PRIVATE;
      o_mem_we <= 1'b0;
      o_mem_addr <= WORD_RST;
      o_mem_be <= 4'h0;
      o_mem_wdata <= WORD_RST;
    end else if (launch_reg) begin
      o_mem_req <= 1'b1;
      // segment fixed by the group, never checked per address
      o_mem_seg <= seg_reg;
      o_mem_we <= (state_reg == SMD_STORE) || (state_reg == SMD_ATOM_WR);
      o_mem_addr <= acc_addr;
      o_mem_be <= acc_be;
      // word stores from consecutive data registers
      o_mem_wdata <= acc_wdata;
    end else if (done) begin
      o_mem_req <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Destination write-back
  // ----------------------------------------------------------------
  logic [7:0] ld_byte;
  logic [15:0] ld_half;

  assign ld_byte = i_mem_rdata[{addr_reg[1:0], 3'b000} +: 8];
  assign ld_half = addr_reg[1] ? i_mem_rdata[31:16] : i_mem_rdata[15:0];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_valid <= 1'b0;
      o_wb_idx <= IDX_RST;
      o_wb_data <= WORD_RST;
      o_wb_lo_en <= 1'b0;
      o_wb_hi_en <= 1'b0;
    end else begin
      o_wb_valid <= done && (state_reg == SMD_LOAD || state_reg == SMD_ATOM_RD);
      o_wb_idx <= idx_reg;
      o_wb_lo_en <= 1'b1;
      o_wb_hi_en <= 1'b1;
      // words land unconverted at consecutive offsets
      o_wb_data <= i_mem_rdata;
      if (state_reg == SMD_LOAD) begin
        unique case (op_reg)
          OP_LOAD_BYTE_ZERO_EXT: o_wb_data <= {24'h0, ld_byte};
          OP_LOAD_BYTE_SIGN_EXT: o_wb_data <= {{24{ld_byte[7]}}, ld_byte};
          OP_LOAD_HALF_ZERO_EXT: o_wb_data <= {16'h0, ld_half};
          OP_LOAD_HALF_SIGN_EXT: o_wb_data <= {{16{ld_half[15]}}, ld_half};
          // padded with zero even for the signed forms
          OP_LOAD_BYTE_LOW_HALF, OP_LOAD_SBYTE_LOW_HALF: begin
            o_wb_data <= {16'h0, 8'h0, ld_byte};
            o_wb_hi_en <= 1'b0;
          end
          OP_LOAD_BYTE_UPPER_HALF, OP_LOAD_SBYTE_UPPER_HALF: begin
            o_wb_data <= {8'h0, ld_byte, 16'h0};
            o_wb_lo_en <= 1'b0;
          end
          OP_LOAD_HALF_LOW: begin
            o_wb_data <= {16'h0, ld_half};
            o_wb_hi_en <= 1'b0;
          end
          OP_LOAD_HALF_UPPER: begin
            o_wb_data <= {ld_half, 16'h0};
            o_wb_lo_en <= 1'b0;
          end
          default: o_wb_data <= i_mem_rdata;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_private_route: assert property (
    accept && i_issue_seg == SMD_SEG_PRIVATE |-> ##2 o_mem_req && o_mem_seg == SMD_SEG_PRIVATE)
    else $error("private access not routed to private space");

  a_global_route: assert property (
    accept && i_issue_seg == SMD_SEG_GLOBAL |-> ##2 o_mem_req && o_mem_seg == SMD_SEG_GLOBAL)
    else $error("global access not routed to global memory");

  a_byte_zero: assert property (
    done && state_reg == SMD_LOAD && op_reg == OP_LOAD_BYTE_ZERO_EXT
    |=> o_wb_valid && o_wb_data == {24'h0, $past(ld_byte)})
    else $error("byte load not zero extended");

  a_byte_sign: assert property (
    done && state_reg == SMD_LOAD && op_reg == OP_LOAD_BYTE_SIGN_EXT
    |=> o_wb_data == {{24{$past(ld_byte[7])}}, $past(ld_byte)})
    else $error("byte load not sign extended");

  a_half_ext: assert property (
    done && state_reg == SMD_LOAD && op_reg == OP_LOAD_HALF_SIGN_EXT
    |=> o_wb_data[31:16] == {16{$past(ld_half[15])}})
    else $error("halfword load extension wrong");

  a_word_order: assert property (
    done && state_reg == SMD_LOAD && op_reg >= OP_LOAD_WORD_FIRST && op_reg <= OP_LOAD_WORD_LAST
    |=> o_wb_idx == $past(idx_reg) && o_wb_data == $past(i_mem_rdata))
    else $error("word load order or data wrong");

  a_store_byte: assert property (
    o_mem_req && op_reg == OP_STORE_BYTE_UPPER_HALF
    |-> o_mem_we && o_mem_wdata[7:0] == data_reg[0][23:16] && $onehot(o_mem_be))
    else $error("upper byte store data wrong");

  a_store_half: assert property (
    o_mem_req && op_reg == OP_STORE_HALF_UPPER |-> o_mem_wdata[15:0] == data_reg[0][31:16])
    else $error("upper halfword store data wrong");

  a_cas_result: assert property (
    o_mem_req && o_mem_we && op_reg == OP_COMPARE_EXCHANGE
    |-> o_mem_wdata == ((old_reg[31:0] == data_reg[1]) ? data_reg[0] : old_reg[31:0]))
    else $error("compare exchange wrote wrong value");

  a_inc_wrap: assert property (
    o_mem_req && o_mem_we && op_reg == OP_WRAP_INCREMENT && old_reg[31:0] >= data_reg[0]
    |-> o_mem_wdata == WORD_RST)
    else $error("wrapping increment did not wrap");

endmodule

// ==== tb/smd_mem_model.sv ====
`timescale 1ns/1ps
module smd_mem_model (
  input wire logic i_clk, // Core clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_req, // Request from the block
  input wire logic i_seg, // 0 private, 1 global
  input wire logic i_we, // Write access
  input wire logic [31:0] i_addr, // Byte address
  input wire logic [3:0] i_be, // Byte lanes
  input wire logic [31:0] i_wdata, // Write data
  input wire logic [1:0] i_wait, // Extra cycles before ack
  output logic o_ack, // One-cycle completion
  output logic [31:0] o_rdata // Read word, valid with ack
);
  // Two small spaces, indexed by word; the bench preloads and inspects them
  logic [31:0] mem [2][16];
  logic [1:0] cnt_reg;

  // Outside ack the read bus toggles, so a stale word never passes as fresh
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      cnt_reg <= 2'h0;
      o_rdata <= 32'h0;
    end else if (i_req && !o_ack && cnt_reg == i_wait) begin
      o_ack <= 1'b1;
      cnt_reg <= 2'h0;
      o_rdata <= mem[i_seg][i_addr[5:2]];
      for (int b = 0; b < 4; b++) begin
        if (i_we && i_be[b]) begin
          mem[i_seg][i_addr[5:2]][8*b +: 8] <= i_wdata[8*b +: 8];
        end
      end
    end else begin
      o_ack <= 1'b0;
      cnt_reg <= (i_req && !o_ack) ? cnt_reg + 2'h1 : 2'h0;
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// ==== tb/segment_memory_op_decode_bench.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      $display("[ERR] %s exp %0h got %0h", n, e, g); \
      num_errors++; \
    end \
  end
module segment_memory_op_decode_bench;
  import smd_pkg::*;
  logic clk, rst_n, valid, seg, ready, req, mseg, we, lock, ack, wbv, lo, hi, ill;
  logic [6:0] op;
  logic [31:0] addr, maddr, wdata, rdata, wbd;
  logic [3:0][31:0] data;
  logic [3:0] be;
  logic [1:0] mem_wait, wbi;
  logic [35:0] wbq[$];
  int num_errors, tests_run, ill_cnt, req_cnt, lk_cnt;

  smd_decode DUT (.i_clk(clk), .i_rst_n(rst_n), .i_issue_valid(valid), .o_issue_ready(ready),
    .i_issue_seg(seg), .i_issue_op(op), .i_issue_addr(addr), .i_issue_data(data),
    .o_mem_req(req), .o_mem_seg(mseg), .o_mem_we(we), .o_mem_addr(maddr), .o_mem_be(be),
    .o_mem_wdata(wdata), .o_mem_lock(lock), .i_mem_ack(ack), .i_mem_rdata(rdata),
    .o_wb_valid(wbv), .o_wb_idx(wbi), .o_wb_data(wbd), .o_wb_lo_en(lo), .o_wb_hi_en(hi),
    .o_illegal(ill));
  smd_mem_model M (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_seg(mseg), .i_we(we),
    .i_addr(maddr), .i_be(be), .i_wdata(wdata), .i_wait(mem_wait), .o_ack(ack),
    .o_rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (wbv === 1'b1) wbq.push_back({wbi, lo, hi, wbd});
    if (ill === 1'b1) ill_cnt++;
    if (ack === 1'b1) req_cnt++;
    if (ack === 1'b1 && lock === 1'b1) lk_cnt++;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic issue(input logic s, input logic [6:0] o, input logic [31:0] a,
    input logic [3:0][31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    valid <= 1'b1;
    seg <= s;
    op <= o;
    addr <= a;
    data <= d;
    @(posedge clk);
    valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    while (ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 200) num_errors++;
    @(posedge clk);
    #1;
  endtask

  task automatic chk_wb(input logic [1:0] i, input logic l, input logic h, input logic [31:0] v);
    logic [35:0] g;
    g = (wbq.size() > 0) ? wbq.pop_front() : 36'hx;
    g[31:0] = g[31:0] & {{16{h}}, {16{l}}};
    `CHK("wb", {i, l, h, v}, g)
  endtask

  // Expected {lo, hi, data} of a sub-word load from word w at lane a
  function automatic logic [33:0] exp_ld(input logic [6:0] o, input logic [31:0] w,
    input logic [1:0] a);
    logic [7:0] b;
    logic [15:0] h, v;
    b = w[8*a +: 8];
    h = a[1] ? w[31:16] : w[15:0];
    case (o)
      7'h10: return {2'b11, 24'h0, b};
      7'h11: return {2'b11, {24{b[7]}}, b};
      7'h12: return {2'b11, 16'h0, h};
      7'h13: return {2'b11, {16{h[15]}}, h};
      default: begin
        v = (o < 7'h24) ? {8'h0, b} : h;
        return o[0] ? {2'b01, v, 16'h0} : {2'b10, 16'h0, v};
      end
    endcase
  endfunction

  function automatic logic [31:0] atom(input logic [6:0] o, input logic [31:0] t, d, c);
    case (o)
      OP_EXCHANGE: return d;
      OP_COMPARE_EXCHANGE: return (t == c) ? d : t;
      OP_ATOM_ADD: return t + d;
      OP_ATOM_SUB: return t - d;
      OP_ATOM_SMIN: return ($signed(d) < $signed(t)) ? d : t;
      OP_ATOM_UMIN: return (d < t) ? d : t;
      OP_ATOM_SMAX: return ($signed(d) > $signed(t)) ? d : t;
      OP_ATOM_UMAX: return (d > t) ? d : t;
      OP_ATOM_AND: return t & d;
      OP_ATOM_OR: return t | d;
      OP_ATOM_XOR: return t ^ d;
      OP_WRAP_INCREMENT: return (t >= d) ? 32'h0 : t + 32'h1;
      default: return (t == 32'h0 || t > d) ? d : t - 32'h1;
    endcase
  endfunction

  task automatic t_sub_loads();
    logic [31:0] w [2];
    logic [33:0] e;
    logic [6:0] o;
    w[0] = 32'h80f27f01;
    w[1] = 32'h017f80fe;
    M.mem[0][4] = w[0];
    M.mem[1][4] = w[1];
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 10; k++) begin
        o = (k < 4) ? 7'h10 + k[6:0] : 7'h1c + k[6:0];
        if (s == 0 && k > 3) continue;
        for (int a = 0; a < 4; a++) begin
          if (a[0] && ((o < 7'h20) ? o[1] : o[2])) continue;
          e = exp_ld(o, w[s], a[1:0]);
          issue(s[0], o, 32'h10 + a, '0);
          chk_wb(2'h0, e[33], e[32], e[31:0]);
        end
      end
    end
    $display("test sub_loads done");
  endtask

  // word order into consecutive destinations, slow memory
  task automatic t_multi_load();
    mem_wait = 2'h2;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 4; k++) M.mem[s][8+k] = 32'hc0de0000 + 32'h100 * s + k;
      for (int n = 1; n < 5; n++) begin
        issue(s[0], 7'h13 + n[6:0], 32'h20, '0);
        for (int k = 0; k < n; k++) begin
          chk_wb(k[1:0], 1'b1, 1'b1, 32'hc0de0000 + 32'h100 * s + k);
        end
        `CHK("extra wb", 0, wbq.size())
      end
    end
    mem_wait = 2'h0;
    $display("test multi_load done");
  endtask

  task automatic t_stores();
    logic [31:0] e [4] = '{32'h5555d455, 32'h55b25555, 32'hc3d45555, 32'h5555a1b2};
    logic [1:0] ln [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
    logic [3:0][31:0] d;
    d = {32'h44444444, 32'h33333333, 32'h22222222, 32'ha1b2c3d4};
    for (int k = 0; k < 4; k++) begin
      M.mem[1][9] = 32'h55555555;
      issue(1'b1, 7'h18 + k[6:0], {28'h2, 2'h1, ln[k]}, d);
      `CHK("store", e[k], M.mem[1][9])
    end
    for (int n = 1; n < 5; n++) begin
      for (int k = 0; k < 4; k++) M.mem[1][12+k] = 32'h0;
      issue(1'b1, 7'h1b + n[6:0], 32'h30, d);
      for (int k = 0; k < 4; k++) begin
        `CHK("store words", (k < n) ? d[k] : 32'h0, M.mem[1][12+k])
      end
    end
    `CHK("store wb", 0, wbq.size())
    $display("test stores done");
  endtask

  task automatic t_atomics();
    logic [31:0] st [3] = '{32'hfffffff0, 32'h3, 32'h0};
    logic [31:0] sd [3] = '{32'h5, 32'h7, 32'h80000000};
    logic [31:0] sc [3] = '{32'hfffffff0, 32'h9, 32'h0};
    int l0;
    for (int s = 0; s < 3; s++) begin
      mem_wait = s[1:0];
      for (int k = 64; k < 77; k++) begin
        M.mem[1][14] = st[s];
        l0 = lk_cnt;
        issue(1'b1, k[6:0], 32'h38, {64'h0, sc[s], sd[s]});
        chk_wb(2'h0, 1'b1, 1'b1, st[s]);
        `CHK("atomic mem", atom(k[6:0], st[s], sd[s], sc[s]), M.mem[1][14])
        `CHK("locked acks", 2, lk_cnt - l0)
      end
    end
    mem_wait = 2'h0;
    $display("test atomics done");
  endtask

  task automatic t_wide();
    logic [63:0] old, nw;
    old = 64'h8000000112345678;
    nw = 64'hfedcba9876543210;
    for (int k = 0; k < 3; k++) begin
      {M.mem[1][13], M.mem[1][12]} = old;
      issue(1'b1, (k == 0) ? OP_EXCHANGE_WIDE : OP_COMPARE_EXCHANGE_WIDE, 32'h30,
        {(k == 2) ? ~old : old, nw});
      chk_wb(2'h0, 1'b1, 1'b1, old[31:0]);
      chk_wb(2'h1, 1'b1, 1'b1, old[63:32]);
      `CHK("wide mem", (k == 2) ? old : nw, {M.mem[1][13], M.mem[1][12]})
    end
    $display("test wide done");
  endtask

  // opcodes outside each group are refused
  task automatic t_illegal();
    logic [7:0] bad [9] = '{8'h18, 8'h20, 8'h40, 8'ha6, 8'hbf, 8'hcd, 8'hdf, 8'he2, 8'h80};
    int i0, r0;
    for (int k = 0; k < 9; k++) begin
      i0 = ill_cnt;
      r0 = req_cnt;
      issue(bad[k][7], bad[k][6:0], 32'h0, '0);
      `CHK("illegal", i0 + 1, ill_cnt)
      `CHK("no access", r0, req_cnt)
      `CHK("no wb", 0, wbq.size())
    end
    $display("test illegal done");
  endtask

  initial begin
    #100000;
    num_errors++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    valid = 1'b0;
    seg = 1'b0;
    op = 7'h0;
    addr = 32'h0;
    data = '0;
    mem_wait = 2'h0;
    @(posedge clk);
    #1;
    `CHK("reset ready", 1'b1, ready)
    `CHK("reset req", 1'b0, req)
    @(posedge clk);
    rst_n <= 1'b1;
    t_sub_loads();
    t_multi_load();
    t_stores();
    t_atomics();
    t_wide();
    t_illegal();
    results();
  end
endmodule
